// ### hw/length_timer_core.sv
// Programmable-length timer counting core with clock select, dividers and flags.
// Assumes a register master with one-cycle strobes and read data one cycle later.
module length_timer_core
(
   // Clock and reset
   input  wire logic                                  mclk,
   input  wire logic                                  rst_n,
   // Register port
   input  wire logic [length_timer_pkg::ADDR_W-1:0]   regAddr,
   input  wire logic [length_timer_pkg::DATA_W-1:0]   regWdata,
   input  wire logic                                  regWrite,
   input  wire logic                                  regRead,
   output logic      [length_timer_pkg::DATA_W-1:0]   regRdata,
   // Clock sources
   input  wire logic                                  extClk,
   input  wire logic                                  auxClk,
   input  wire logic                                  subClk,
   // Status
   output logic      [length_timer_pkg::DATA_W-1:0]   timerCount,
   output logic                                       overflowFlag,
   output logic                                       ccFlag
);

   // ************************************************************
   // Register state
   // ************************************************************
   logic [1:0]  sourceSel_q;
   logic [1:0]  inDiv_q;
   logic [1:0]  mode_q;
   logic [1:0]  length_q;
   logic [2:0]  expand_q;
   logic [15:0] period_q;
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic        dirDown_q;
   logic        dirDown_d;
   logic        ovf_q;
   logic        cc_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;

   // ************************************************************
   // Address decode
   // ************************************************************
   logic wrCtrl;
   logic wrCh0Ctrl;
   logic wrCount;
   logic wrPeriod;
   logic wrExpand;
   logic clearPulse;

   assign wrCtrl     = regWrite && (regAddr == length_timer_pkg::OFS_CONTROL);
   assign wrCh0Ctrl  = regWrite && (regAddr == length_timer_pkg::OFS_CH0CTRL);
   assign wrCount    = regWrite && (regAddr == length_timer_pkg::OFS_COUNT);
   assign wrPeriod   = regWrite && (regAddr == length_timer_pkg::OFS_CH0VALUE);
   assign wrExpand   = regWrite && (regAddr == length_timer_pkg::OFS_EXPANSION);
   assign clearPulse = wrCtrl && regWdata[length_timer_pkg::POS_CLEAR];

   // ************************************************************
   // Clock source and dividers
   // ************************************************************
   logic       srcPulse;
   logic       stage1Pulse;
   logic       tick;
   logic [2:0] stage1Ratio;

   assign stage1Ratio = (inDiv_q == 2'h0) ? 3'h0 :
                        (inDiv_q == 2'h1) ? 3'h1 :
                        (inDiv_q == 2'h2) ? 3'h3 : 3'h7;

   clock_edge_select u_source
   (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .extClk    (extClk),
      .auxClk    (auxClk),
      .subClk    (subClk),
      .sourceSel (sourceSel_q),
      .srcPulse  (srcPulse)
   );

   tick_divider #(.W(3)) u_stage1
   (
      .mclk          (mclk),
      .rst_n         (rst_n),
      .clear         (clearPulse),
      .ratioMinusOne (stage1Ratio),
      .inPulse       (srcPulse),
      .outPulse      (stage1Pulse)
   );

   tick_divider #(.W(3)) u_stage2
   (
      .mclk          (mclk),
      .rst_n         (rst_n),
      .clear         (clearPulse),
      .ratioMinusOne (expand_q),
      .inPulse       (stage1Pulse),
      .outPulse      (tick)
   );

   // ************************************************************
   // Count maximum and next count
   // ************************************************************
   logic [15:0] countMax;
   logic [15:0] countInc;
   logic [15:0] countDec;
   logic        counting;
   logic        periodZero;
   logic        udAsCont;
   logic        setOvf;
   logic        setCc;

   assign countMax   = (length_q == length_timer_pkg::LEN_8)  ? length_timer_pkg::MAX_8 :
                       (length_q == length_timer_pkg::LEN_10) ? length_timer_pkg::MAX_10 :
                       (length_q == length_timer_pkg::LEN_12) ? length_timer_pkg::MAX_12 :
                                                                length_timer_pkg::MAX_16;
   assign countInc   = count_q + length_timer_pkg::ONE_WORD;
   assign countDec   = count_q - length_timer_pkg::ONE_WORD;
   assign counting   = tick && (mode_q != length_timer_pkg::MODE_STOP) && !wrCount && !clearPulse;
   assign periodZero = (period_q == length_timer_pkg::ZERO_WORD);
   assign udAsCont   = (period_q > countMax);

   always_comb
   begin
      count_d   = count_q;
      dirDown_d = dirDown_q;
      setOvf    = 1'b0;
      setCc     = 1'b0;
      case (mode_q)
         length_timer_pkg::MODE_UP:
         begin
            if (periodZero)
            begin
               count_d   = length_timer_pkg::ZERO_WORD;
               dirDown_d = 1'b0;
            end
            else if (count_q >= period_q)
            begin
               count_d = length_timer_pkg::ZERO_WORD;
               setOvf  = (count_q == period_q);
            end
            else
            begin
               count_d = countInc;
               setCc   = (countInc == period_q);
            end
         end
         length_timer_pkg::MODE_CONT:
         begin
            count_d = (count_q >= countMax) ? length_timer_pkg::ZERO_WORD : countInc;
            setOvf  = (count_q >= countMax);
            setCc   = (count_d == period_q);
         end
         length_timer_pkg::MODE_UPDOWN:
         begin
            if (periodZero)
            begin
               count_d   = length_timer_pkg::ZERO_WORD;
               dirDown_d = 1'b0;
            end
            else if (udAsCont)
            begin
               count_d = (count_q >= countMax) ? length_timer_pkg::ZERO_WORD : countInc;
               setOvf  = (count_q >= countMax);
            end
            else if (dirDown_q)
            begin
               if (count_q <= length_timer_pkg::ONE_WORD)
               begin
                  count_d   = length_timer_pkg::ZERO_WORD;
                  dirDown_d = 1'b0;
                  setOvf    = (count_q == length_timer_pkg::ONE_WORD);
               end
               else
                  count_d = countDec;
            end
            else if (count_q >= period_q)
            begin
               count_d   = countDec;
               dirDown_d = (count_q != length_timer_pkg::ONE_WORD);
               setOvf    = (count_q == length_timer_pkg::ONE_WORD);
            end
            else
            begin
               count_d = countInc;
               setCc   = (countInc == period_q);
            end
         end
         default: count_d = count_q;
      endcase
   end

   // ************************************************************
   // Counter and direction
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_q   <= length_timer_pkg::ZERO_WORD;
         dirDown_q <= 1'b0;
      end
      else if (clearPulse)
      begin
         count_q   <= length_timer_pkg::ZERO_WORD;
         dirDown_q <= 1'b0;
      end
      else if (wrCount)
         count_q <= regWdata & countMax;
      else if (counting)
      begin
         count_q   <= count_d & countMax;
         dirDown_q <= dirDown_d;
      end
   end

   // ************************************************************
   // Flags: hardware set wins over software clear
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ovf_q <= 1'b0;
         cc_q  <= 1'b0;
      end
      else
      begin
         if (counting && setOvf)
            ovf_q <= 1'b1;
         else if (wrCtrl)
            ovf_q <= regWdata[length_timer_pkg::POS_OVF];
         if (counting && setCc)
            cc_q <= 1'b1;
         else if (wrCh0Ctrl)
            cc_q <= regWdata[length_timer_pkg::POS_CCFLAG];
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sourceSel_q <= length_timer_pkg::SRC_EXT;
         inDiv_q     <= 2'h0;
         mode_q      <= length_timer_pkg::MODE_STOP;
         length_q    <= length_timer_pkg::LEN_16;
         expand_q    <= 3'h0;
         period_q    <= length_timer_pkg::ZERO_WORD;
      end
      else
      begin
         if (wrCtrl)
         begin
            sourceSel_q <= regWdata[length_timer_pkg::POS_SOURCE +: 2];
            inDiv_q     <= regWdata[length_timer_pkg::POS_INDIV +: 2];
            mode_q      <= regWdata[length_timer_pkg::POS_MODE +: 2];
            length_q    <= regWdata[length_timer_pkg::POS_LENGTH +: 2];
         end
         if (wrExpand)
            expand_q <= regWdata[length_timer_pkg::POS_EXPAND +: 3];
         if (wrPeriod)
            period_q <= regWdata;
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   logic [15:0] ctrlRead;
   logic [15:0] ch0Read;
   logic [15:0] expandRead;

   assign ctrlRead   = {3'h0, length_q, 1'b0, sourceSel_q, inDiv_q, mode_q, 3'h0, ovf_q};
   assign ch0Read    = {15'h0000, cc_q};
   assign expandRead = {13'h0000, expand_q};
   assign rdata_d    = (regAddr == length_timer_pkg::OFS_CONTROL)   ? ctrlRead :
                       (regAddr == length_timer_pkg::OFS_CH0CTRL)   ? ch0Read :
                       (regAddr == length_timer_pkg::OFS_COUNT)     ? count_q :
                       (regAddr == length_timer_pkg::OFS_CH0VALUE)  ? period_q :
                       (regAddr == length_timer_pkg::OFS_EXPANSION) ? expandRead :
                                                                      length_timer_pkg::ZERO_WORD;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= length_timer_pkg::ZERO_WORD;
      else if (regRead)
         rdata_q <= rdata_d;
      else
         rdata_q <= length_timer_pkg::ZERO_WORD;
   end

   // ************************************************************
   // Status outputs
   // ************************************************************
   logic [15:0] countOut_q;
   logic        ovfOut_q;
   logic        ccOut_q;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         countOut_q <= length_timer_pkg::ZERO_WORD;
         ovfOut_q   <= 1'b0;
         ccOut_q    <= 1'b0;
      end
      else
      begin
         countOut_q <= count_q;
         ovfOut_q   <= ovf_q;
         ccOut_q    <= cc_q;
      end
   end

   assign regRdata     = rdata_q;
   assign timerCount   = countOut_q;
   assign overflowFlag = ovfOut_q;
   assign ccFlag       = ccOut_q;

   // ************************************************************
   // Assertions
   // ************************************************************
   chk_clear_zeroes: assert property (@(posedge mclk) disable iff (!rst_n)
      clearPulse |=> (count_q == 16'h0000) && !dirDown_q)
      else $error("clear did not zero count and direction");
   chk_write_masked: assert property (@(posedge mclk) disable iff (!rst_n)
      wrCount && !clearPulse |=> count_q == ($past(regWdata) & $past(countMax)))
      else $error("count write not masked to length");
   chk_write_noflag: assert property (@(posedge mclk) disable iff (!rst_n)
      wrCount && !ovf_q && !wrCtrl |=> !ovf_q)
      else $error("count write raised overflow");
   chk_stop_holds: assert property (@(posedge mclk) disable iff (!rst_n)
      (mode_q == 2'h0) && !regWrite |=> $stable(count_q))
      else $error("counter moved in stop mode");
   chk_up_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
      counting && (mode_q == 2'h1) && !periodZero && (count_q == period_q)
      |=> (count_q == 16'h0000) && ovf_q)
      else $error("up mode did not wrap with overflow");
   chk_up_compare: assert property (@(posedge mclk) disable iff (!rst_n)
      counting && (mode_q == 2'h1) && (countInc == period_q) && !periodZero |=> cc_q)
      else $error("up mode compare flag missing");
   chk_cont_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
      counting && (mode_q == 2'h2) && (count_q == countMax) |=> (count_q == 16'h0000) && ovf_q)
      else $error("continuous mode did not wrap at maximum");
   chk_ud_reverse: assert property (@(posedge mclk) disable iff (!rst_n)
      counting && (mode_q == 2'h3) && !udAsCont && !periodZero && !dirDown_q && (count_q == period_q)
      |=> (dirDown_q == ($past(period_q) != 16'h0001)) && (count_q == $past(period_q) - 16'h0001))
      else $error("up/down did not reverse at period");
   chk_ud_bottom: assert property (@(posedge mclk) disable iff (!rst_n)
      counting && (mode_q == 2'h3) && !udAsCont && dirDown_q && (count_q == 16'h0001)
      |=> ovf_q && !dirDown_q ##1 (count_q <= 16'h0001))
      else $error("up/down bottom step wrong");
   chk_dir_kept: assert property (@(posedge mclk) disable iff (!rst_n)
      (mode_q == 2'h0) && !clearPulse |=> $stable(dirDown_q))
      else $error("direction lost while stopped");
   chk_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
      ovf_q && !wrCtrl |=> ovf_q)
      else $error("overflow flag dropped without clear");

endmodule : length_timer_core

// ### hw/length_timer_pkg.sv
// Constants, register map and field layout of the programmable-length timer core.
// Assumes a single 20 MHz clock and a simple strobe register port.
package length_timer_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 16;
   localparam logic [7:0]  OFS_CONTROL   = 8'h00;
   localparam logic [7:0]  OFS_CH0CTRL   = 8'h04;
   localparam logic [7:0]  OFS_COUNT     = 8'h08;
   localparam logic [7:0]  OFS_CH0VALUE  = 8'h0C;
   localparam logic [7:0]  OFS_EXPANSION = 8'h10;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int          POS_OVF       = 0;
   localparam int          POS_CLEAR     = 2;
   localparam int          POS_MODE      = 4;
   localparam int          POS_INDIV     = 6;
   localparam int          POS_SOURCE    = 8;
   localparam int          POS_LENGTH    = 11;
   localparam int          POS_CCFLAG    = 0;
   localparam int          POS_EXPAND    = 0;

   // ************************************************************
   // Codes and reset values
   // ************************************************************
   localparam logic [1:0]  MODE_STOP     = 2'h0;
   localparam logic [1:0]  MODE_UP       = 2'h1;
   localparam logic [1:0]  MODE_CONT     = 2'h2;
   localparam logic [1:0]  MODE_UPDOWN   = 2'h3;
   localparam logic [1:0]  SRC_EXT       = 2'h0;
   localparam logic [1:0]  SRC_AUX       = 2'h1;
   localparam logic [1:0]  SRC_SUB       = 2'h2;
   localparam logic [1:0]  SRC_EXT_INV   = 2'h3;
   localparam logic [1:0]  LEN_8         = 2'h0;
   localparam logic [1:0]  LEN_10        = 2'h1;
   localparam logic [1:0]  LEN_12        = 2'h2;
   localparam logic [1:0]  LEN_16        = 2'h3;
   localparam logic [15:0] MAX_8         = 16'h00FF;
   localparam logic [15:0] MAX_10        = 16'h03FF;
   localparam logic [15:0] MAX_12        = 16'h0FFF;
   localparam logic [15:0] MAX_16        = 16'hFFFF;
   localparam logic [15:0] ZERO_WORD     = 16'h0000;
   localparam logic [15:0] ONE_WORD      = 16'h0001;

endpackage : length_timer_pkg

// ### hw/clock_edge_select.sv
// Clock source multiplexer and rising-edge detector for the timer core.
// Assumes all source inputs are synchronous to mclk and slower than half its rate.
module clock_edge_select
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // Sources
   input  wire logic       extClk,
   input  wire logic       auxClk,
   input  wire logic       subClk,
   input  wire logic [1:0] sourceSel,
   // Selected source edge
   output logic            srcPulse
);

   logic srcLevel;
   logic prevLevel_q;

   assign srcLevel = (sourceSel == length_timer_pkg::SRC_EXT) ? extClk :
                     (sourceSel == length_timer_pkg::SRC_AUX) ? auxClk :
                     (sourceSel == length_timer_pkg::SRC_SUB) ? subClk : ~extClk;
   assign srcPulse = srcLevel & ~prevLevel_q;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         prevLevel_q <= 1'b0;
      else
         prevLevel_q <= srcLevel;
   end

endmodule : clock_edge_select

// ### hw/tick_divider.sv
// Pulse divider stage: passes every (ratioMinusOne+1)-th input pulse.
// Assumes clear is a one-cycle pulse; the first pulse after clear passes.
module tick_divider #(
   parameter int W = 3
)
(
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // Control
   input  wire logic         clear,
   input  wire logic [W-1:0] ratioMinusOne,
   // Pulses
   input  wire logic         inPulse,
   output logic              outPulse
);

   logic [W-1:0] count_q;
   logic [W-1:0] count_d;

   assign outPulse = inPulse && (count_q == '0);
   assign count_d  = (count_q >= ratioMinusOne) ? '0 : count_q + 1'b1;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         count_q <= '0;
      else if (clear)
         count_q <= '0;
      else if (inPulse)
         count_q <= count_d;
   end

endmodule : tick_divider

// ### testbench/testbench.sv
// Self-checking bench for the programmable-length timer core: register port reads against a queue of notes.
// Assumes the core's package map and clock sources driven as slow levels, idle low.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] A_CTL = length_timer_pkg::OFS_CONTROL;
   localparam logic [7:0] A_CC  = length_timer_pkg::OFS_CH0CTRL;
   localparam logic [7:0] A_CNT = length_timer_pkg::OFS_COUNT;
   localparam logic [7:0] A_PER = length_timer_pkg::OFS_CH0VALUE;
   localparam logic [7:0] A_EXP = length_timer_pkg::OFS_EXPANSION;
   logic        mclk     = 1'b0;
   logic        rst_n    = 1'b0;
   logic [7:0]  regAddr  = 8'h00;
   logic [15:0] regWdata = 16'h0000;
   logic        regWrite = 1'b0;
   logic        regRead  = 1'b0;
   logic [2:0]  clkSrc   = 3'h0;
   logic        rdSeen   = 1'b0;
   logic        stReq    = 1'b0;
   logic [15:0] regRdata;
   logic [15:0] timerCount;
   logic        overflowFlag;
   logic        ccFlag;
   logic [15:0] expQ[$];
   logic [17:0] expS[$];
   int          n_errors = 0;
   int          checked  = 0;

   length_timer_core u_dut (.mclk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
      .extClk(clkSrc[0]), .auxClk(clkSrc[1]), .subClk(clkSrc[2]), .timerCount, .overflowFlag, .ccFlag);

   always #25 mclk = ~mclk;

   task automatic results();
      if (n_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   task automatic cmp(input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value regRdata expected %h seen %h", e, g);
      end
   endtask : cmp

   // Read data stand only in the cycle after the strobe
   always @(posedge mclk)
   begin
      if (rdSeen === 1'b1 && expQ.size() > 0)
         cmp(expQ.pop_front(), regRdata);
      rdSeen <= regRead;
   end

   function automatic logic [15:0] ctl(input int ln, sr, dv, md, cl, ov);
      return 16'(ln << 11 | sr << 8 | dv << 6 | md << 4 | cl << 2 | ov);
   endfunction : ctl

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      expQ.push_back(e);
      @(posedge mclk);
      regRead <= 1'b0;
   endtask : rd

   task automatic cmpStat(input logic [17:0] e, input logic [17:0] g);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value status expected %h seen %h", e, g);
      end
   endtask : cmpStat

   // Status outputs are compared at the falling edge, away from their launch
   always @(negedge mclk)
   begin
      if (stReq === 1'b1 && expS.size() > 0)
         cmpStat(expS.pop_front(), {overflowFlag, ccFlag, timerCount});
   end

   task automatic st(input logic ov, input logic cc, input logic [15:0] e);
      @(posedge mclk);
      expS.push_back({ov, cc, e});
      stReq <= 1'b1;
      @(posedge mclk);
      stReq <= 1'b0;
   endtask : st

   // One source pulse: high two cycles, low three
   task automatic pulse(input int s, input int n);
      repeat (n)
      begin
         @(posedge mclk);
         clkSrc[s] <= 1'b1;
         repeat (2) @(posedge mclk);
         clkSrc[s] <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask : pulse

   task automatic tk(input int n, input logic [15:0] e);
      pulse(0, n);
      rd(A_CNT, e);
   endtask : tk

   initial
   begin
      repeat (6000) @(posedge mclk);
      n_errors++;
      results();
   end

   initial
   begin
      logic [15:0] v;
      logic [15:0] mx;
      void'($urandom(32'h653941DE));
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      rd(A_CTL, 16'h1800);
      rd(8'h14, 16'h0000);
      for (int s = 0; s < 4; s++)
      begin
         wr(A_CTL, ctl(3, s, 0, 0, 0, 0));
         wr(A_CTL, ctl(3, s, 0, 2, 1, 0));
         pulse(1, 1);
         pulse(2, 1);
         tk(1, 16'h0001);
      end
      wr(A_CTL, ctl(3, 3, 0, 0, 0, 0));
      tk(2, 16'h0001);
      st(1'b0, 1'b0, 16'h0001);
      for (int d = 0; d < 4; d++)
      begin
         wr(A_EXP, 16'(2 * d + 1));
         wr(A_CTL, ctl(3, 0, d, 2, 1, 0));
         tk(1, 16'h0001);
         tk((1 << d) * (2 * d + 2) - 1, 16'h0001);
         tk(1, 16'h0002);
      end
      wr(A_EXP, 16'h0000);
      for (int n = 0; n < 3; n++)
      begin
         v = 16'($urandom);
         mx = 16'((1 << (8 + 2 * n)) - 1);
         wr(A_CTL, ctl(n, 0, 0, 2, 1, 0));
         wr(A_CNT, v);
         rd(A_CNT, v & mx);
         wr(A_CNT, mx);
         rd(A_CTL, ctl(n, 0, 0, 2, 0, 0));
         tk(1, 16'h0000);
         tk(1, 16'h0001);
         rd(A_CTL, ctl(n, 0, 0, 2, 0, 1));
      end
      wr(A_CC, 16'h0000);
      wr(A_PER, 16'h0003);
      wr(A_CTL, ctl(3, 0, 0, 1, 1, 0));
      wr(A_CNT, 16'h0003);
      rd(A_CC, 16'h0000);
      tk(1, 16'h0000);
      wr(A_CTL, ctl(3, 0, 0, 1, 0, 0));
      tk(3, 16'h0003);
      rd(A_CC, 16'h0001);
      rd(A_CTL, ctl(3, 0, 0, 1, 0, 0));
      tk(1, 16'h0000);
      rd(A_CTL, ctl(3, 0, 0, 1, 0, 1));
      st(1'b1, 1'b1, 16'h0000);
      wr(A_PER, 16'h0000);
      tk(2, 16'h0000);
      wr(A_PER, 16'h0005);
      tk(2, 16'h0002);
      wr(A_CTL, ctl(3, 0, 0, 0, 0, 0));
      wr(A_CNT, 16'h0100);
      wr(A_CTL, ctl(3, 0, 0, 1, 0, 0));
      tk(1, 16'h0000);
      tk(2, 16'h0002);
      wr(A_PER, 16'h0008);
      tk(7, 16'h0000);
      wr(A_CC, 16'h0000);
      wr(A_PER, 16'h0003);
      wr(A_CTL, ctl(3, 0, 0, 3, 1, 0));
      tk(4, 16'h0002);
      rd(A_CC, 16'h0001);
      wr(A_CTL, ctl(3, 0, 0, 0, 0, 0));
      pulse(0, 2);
      wr(A_CTL, ctl(3, 0, 0, 3, 0, 0));
      tk(1, 16'h0001);
      rd(A_CTL, ctl(3, 0, 0, 3, 0, 0));
      tk(1, 16'h0000);
      rd(A_CTL, ctl(3, 0, 0, 3, 0, 1));
      st(1'b1, 1'b1, 16'h0000);
      tk(4, 16'h0002);
      wr(A_PER, 16'h0006);
      tk(2, 16'h0000);
      tk(7, 16'h0005);
      wr(A_CTL, ctl(3, 0, 0, 3, 1, 0));
      rd(A_CNT, 16'h0000);
      tk(2, 16'h0002);
      wr(A_PER, 16'h0001);
      tk(1, 16'h0001);
      tk(4, 16'h0001);
      wr(A_PER, 16'h01FF);
      wr(A_CTL, ctl(0, 0, 0, 3, 0, 0));
      wr(A_CNT, 16'h00FE);
      tk(2, 16'h0000);
      st(1'b1, 1'b1, 16'h0000);
      repeat (3) @(posedge mclk);
      results();
   end
endmodule : testbench
